// file: core/sdhb_map.svh
// Offsets, bit positions, reset values and timing counts of the transceiver status, mode and config bank.
// Assumes a 250 MHz core clock and an Avalon-MM byte address with one 32-bit word per register.
`ifndef SDHB_MAP_SVH
`define SDHB_MAP_SVH
`define SDHB_OFS_MODE_LOW   6'h00
`define SDHB_OFS_MODE_HIGH  6'h04
`define SDHB_OFS_CFG_LINE   6'h08
`define SDHB_OFS_CFG_CELL   6'h0C
`define SDHB_OFS_CFG_PTR    6'h10
`define SDHB_OFS_CFG_CNT    6'h14
`define SDHB_OFS_STATUS     6'h18
`define SDHB_OFS_MASK       6'h1C
`define SDHB_OFS_LATCHED    6'h20
`define SDHB_OFS_H4_VALUE   6'h24
`define SDHB_OFS_LIVE       6'h28
`define SDHB_MODE_LOW_RST_PL  8'h9C
`define SDHB_MODE_LOW_RST_PH  8'hFC
`define SDHB_MODE_HIGH_RST    8'h80
`define SDHB_CFG_LINE_SONET   8'hFF
`define SDHB_CFG_LINE_SDH     8'h00
`define SDHB_CFG_PTR_SONET    8'h00
`define SDHB_CFG_PTR_SDH      8'h16
`define SDHB_CFG_CELL_BASE    8'h88
`define SDHB_CFG_CNT_RST      8'h00
`define SDHB_BIT_CHIP_RESET   0
`define SDHB_BIT_PATH_TERM    6
`define SDHB_BIT_LASER        3
`define SDHB_BIT_XCB2         0
`define SDHB_BIT_C1_VARIANT     7
`define SDHB_BIT_LOF_TIMING     6
`define SDHB_BIT_LOS_RELEASE    5
`define SDHB_BIT_MS_PERSIST     4
`define SDHB_BIT_K1K2_PERSIST   3
`define SDHB_BIT_PFAIL_PERSIST  2
`define SDHB_BIT_LOP_COUNT      1
`define SDHB_BIT_UNDEF_FILL     0
`define SDHB_BIT_H4_POINTER     6
`define SDHB_BIT_OCTET_LEVEL    2
`define SDHB_BIT_CELL_PORT      1
`define SDHB_BIT_DD_EVAL        5
`define SDHB_BIT_SS_EVAL        2
`define SDHB_FRAMES_PER_SEC   13'd8000
`define SDHB_LABEL_REPEAT     3'd5
`define SDHB_CLK_MHZ          250
`define SDHB_LOF_TIME_US      3000
`define SDHB_LABEL_WIN_US     50000
`define SDHB_PERSIST_LONG     4'd5
`define SDHB_PERSIST_SHORT    4'd3
`define SDHB_PFAIL_LONG       4'd10
`define SDHB_LOP_SET          4'd8
`define SDHB_LOP_CLEAR        4'd9
`define SDHB_C1_SECOND        8'h02
`define SDHB_C1_THIRD         8'h03
`define SDHB_C1_FILL          8'hAA
`define SDHB_UNDEF_ZERO       8'h00
`define SDHB_UNDEF_ONES       8'hFF
`define SDHB_EXTRA_OCTET      3'd4
`define SDHB_EXTRA_SINGLE     3'd1
`endif

// file: core/sdhb_pkg.sv
// Types of the transceiver status, mode and config bank.
// Assumes the constants header is compiled alongside.
package sdhb_pkg;
	// Loss-of-signal release states, one-hot.
	typedef enum logic [2:0] {
		SDHB_LOS_CLEAR = 3'b001,
		SDHB_LOS_LOST  = 3'b010,
		SDHB_LOS_WAIT  = 3'b100
	} sdhb_los_e;
	// Whole state of the bank.
	typedef struct packed {
		logic [7:0]  mode_low;
		logic [7:0]  mode_high;
		logic [7:0]  cfg_line;
		logic [7:0]  cfg_cell;
		logic [7:0]  cfg_ptr;
		logic [7:0]  cfg_cnt;
		logic [7:0]  h4_value;
		logic [15:0] status;
		logic [15:0] mask;
		logic [15:0] accum;
		logic [15:0] latched;
		logic [12:0] frame_cnt;
		logic [19:0] lof_cnt;
		logic        lof;
		logic [23:0] win_cnt;
		logic [2:0]  wrong_cnt;
		sdhb_los_e   los_st;
		logic        pat_seen;
		logic        los;
		logic        wait_req;
		logic [31:0] readdata;
		logic        irq;
		logic        tx_section_ferf;
		logic        tx_path_ferf;
		logic        alarm_out;
		logic        laser_on;
		logic        ss_mismatch;
		logic        dd_mismatch;
		logic [7:0]  tx_h4;
		logic [3:0]  ms_persist;
		logic [3:0]  k1k2_persist;
		logic [3:0]  pfail_persist;
		logic [3:0]  lop_count;
		logic [7:0]  c1_second;
		logic [7:0]  c1_third;
		logic [7:0]  undef_fill;
		logic [2:0]  fifo_extra;
		logic [1:0]  tx_ss;
		logic [1:0]  tx_dd;
	} sdhb_state_s;
endpackage

// file: core/sdhb_bank.sv
// Status flags, mode and configuration registers of the transceiver, with an Avalon-MM slave.
// Assumes all pins synchronous to mclk and a one-pulse-per-frame strobe from the framer.
`timescale 1ns/1ps
`include "sdhb_map.svh"
module sdhb_bank #(
	parameter int LOF_CYCLES = `SDHB_LOF_TIME_US * `SDHB_CLK_MHZ,   // Loss-of-frame hold-off in cycles.
	parameter int WIN_CYCLES = `SDHB_LABEL_WIN_US * `SDHB_CLK_MHZ   // Label mismatch window in cycles.
) (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        path_select_pin,
	input  wire logic        standard_select_pin,
	input  wire logic        payload_mode_pin,
	input  wire logic        frame_pulse,
	input  wire logic [7:0]  rx_k2,
	input  wire logic [7:0]  rx_g1,
	input  wire logic        tx_fifo_overflow,
	input  wire logic        tx_fifo_underflow,
	input  wire logic        temperature_warning_n,
	input  wire logic        supply_warning_n,
	input  wire logic        battery_switchover_n,
	input  wire logic        ext_irq_one_n,
	input  wire logic        ext_irq_two,
	input  wire logic        label_wrong,
	input  wire logic        tx_cell_fifo_full,
	input  wire logic        tx_cell_fifo_write,
	input  wire logic        rx_cell_fifo_full,
	input  wire logic        rx_cell_fifo_write,
	input  wire logic        out_of_frame,
	input  wire logic        signal_loss_pin,
	input  wire logic        framing_pattern_ok,
	input  wire logic        excess_b2_detected,
	input  wire logic        auto_laser_shutdown,
	input  wire logic        h1_strobe,
	input  wire logic [7:0]  rx_h1_first,
	input  wire logic [7:0]  rx_h1_later,
	input  wire logic [7:0]  next_cell_pointer,
	output logic             irq,
	output logic             loss_of_frame,
	output logic             loss_of_signal,
	output logic             tx_section_ferf,
	output logic             tx_path_ferf,
	output logic             alarm_signal_output,
	output logic             laser_on,
	output logic             ss_mismatch,
	output logic             dd_mismatch,
	output logic [7:0]       tx_h4,
	output logic [3:0]       ms_alarm_persist,
	output logic [3:0]       k1k2_persist,
	output logic [3:0]       path_fail_persist,
	output logic [3:0]       pointer_loss_count,
	output logic [7:0]       c1_second_byte,
	output logic [7:0]       c1_third_byte,
	output logic [7:0]       undefined_byte_fill,
	output logic [2:0]       tx_fifo_extra_bytes,
	output logic [1:0]       tx_ss_bits,
	output logic [1:0]       tx_dd_bits
);
	import sdhb_pkg::*;

	sdhb_state_s s;        // Registered state.
	sdhb_state_s n;        // Next state.
	sdhb_state_s rst_val;  // Values loaded by the hardware reset.
	logic [15:0] cond;     // Live condition behind each status bit.
	logic        tick;     // One-second boundary.
	logic        wr_go;    // Write takes effect this edge.
	logic        rpt_evt;  // Fifth wrong label inside the window.

	// Hardware reset values; straps are sampled while rst is high, so the sync reset picks them up.
	always_comb
	begin
		rst_val = '0;
		rst_val.mode_low = path_select_pin ? `SDHB_MODE_LOW_RST_PH : `SDHB_MODE_LOW_RST_PL;
		rst_val.mode_high = `SDHB_MODE_HIGH_RST;
		rst_val.cfg_line = standard_select_pin ? `SDHB_CFG_LINE_SDH : `SDHB_CFG_LINE_SONET;
		rst_val.cfg_ptr = standard_select_pin ? `SDHB_CFG_PTR_SDH : `SDHB_CFG_PTR_SONET;
		rst_val.cfg_cell = `SDHB_CFG_CELL_BASE | {6'h00, ~payload_mode_pin, ~standard_select_pin};
		rst_val.cfg_cnt = `SDHB_CFG_CNT_RST;
		rst_val.los_st = SDHB_LOS_CLEAR;
		rst_val.wait_req = 1'b1;
	end

	// All next-state logic: bus, flags, timers and derived line settings.
	always_comb
	begin
		n = s;
		tick = frame_pulse && (s.frame_cnt == `SDHB_FRAMES_PER_SEC - 13'd1);
		rpt_evt = label_wrong && (s.wrong_cnt == `SDHB_LABEL_REPEAT - 3'd1);
		wr_go = avs_write && !s.wait_req;

		// Conditions; pulses count as active only in their own cycle.
		cond = '0;
		cond[0] = (rx_k2[2:0] == 3'b110);
		cond[1] = rx_g1[3];
		cond[2] = tx_fifo_overflow || tx_fifo_underflow;
		cond[3] = tick;
		cond[4] = !temperature_warning_n;
		cond[5] = !supply_warning_n;
		cond[6] = !battery_switchover_n;
		cond[7] = !ext_irq_one_n;
		cond[8] = ext_irq_two;
		cond[9] = label_wrong;
		cond[10] = rpt_evt;
		cond[11] = tx_cell_fifo_full && tx_cell_fifo_write;
		cond[12] = rx_cell_fifo_full && rx_cell_fifo_write;
		cond[13] = s.lof;

		// Bus slave: one wait cycle, read data loaded while waitrequest is still high.
		n.wait_req = 1'b1;
		if ((avs_read || avs_write) && s.wait_req)
		begin
			n.wait_req = 1'b0;
		end
		if (avs_read && s.wait_req)
		begin
			case (avs_address)
				`SDHB_OFS_MODE_LOW:  n.readdata = {24'h000000, s.mode_low};
				`SDHB_OFS_MODE_HIGH: n.readdata = {24'h000000, s.mode_high};
				`SDHB_OFS_CFG_LINE:  n.readdata = {24'h000000, s.cfg_line};
				`SDHB_OFS_CFG_CELL:  n.readdata = {24'h000000, s.cfg_cell};
				`SDHB_OFS_CFG_PTR:   n.readdata = {24'h000000, s.cfg_ptr};
				`SDHB_OFS_CFG_CNT:   n.readdata = {24'h000000, s.cfg_cnt};
				`SDHB_OFS_STATUS:    n.readdata = {16'h0000, s.status};
				`SDHB_OFS_MASK:      n.readdata = {16'h0000, s.mask};
				`SDHB_OFS_LATCHED:   n.readdata = {16'h0000, s.latched};
				`SDHB_OFS_H4_VALUE:  n.readdata = {24'h000000, s.h4_value};
				`SDHB_OFS_LIVE:      n.readdata = {29'h00000000, s.los, s.lof, s.laser_on};
				default:             n.readdata = 32'h00000000;  // Unmapped reads return zero.
			endcase
		end

		// Whole-byte register writes; the loop interface bit is stored as written.
		if (wr_go)
		begin
			case (avs_address)
				`SDHB_OFS_MODE_LOW:  n.mode_low = avs_writedata[7:0];
				`SDHB_OFS_MODE_HIGH: n.mode_high = avs_writedata[7:0];
				`SDHB_OFS_CFG_LINE:  n.cfg_line = avs_writedata[7:0];
				`SDHB_OFS_CFG_CELL:  n.cfg_cell = avs_writedata[7:0];
				`SDHB_OFS_CFG_PTR:   n.cfg_ptr = avs_writedata[7:0];
				`SDHB_OFS_CFG_CNT:   n.cfg_cnt = avs_writedata[7:0];
				`SDHB_OFS_MASK:      n.mask = avs_writedata[15:0];
				`SDHB_OFS_H4_VALUE:  n.h4_value = avs_writedata[7:0];
				default:             n.mask = s.mask;  // Other offsets ignore writes here; a status write is handled by the sticky-flag logic below.
			endcase
		end

		// Shutdown beats a simultaneous processor write, so the laser never comes back on by accident.
		if (auto_laser_shutdown)
		begin
			n.mode_high[`SDHB_BIT_LASER] = 1'b0;
		end

		// Sticky flags: write one clears, an active condition keeps the bit and a new event wins.
		if (wr_go && (avs_address == `SDHB_OFS_STATUS))
		begin
			n.status = s.status & ~(avs_writedata[15:0] & ~cond);
		end
		n.status = n.status | cond;

		// One-second sampling: accumulate, then hand over to the readout register.
		if (frame_pulse)
		begin
			n.frame_cnt = tick ? 13'd0 : s.frame_cnt + 13'd1;
		end
		if (tick)
		begin
			n.latched = s.accum | cond;
			n.accum = '0;
		end
		else
		begin
			n.accum = s.accum | cond;
		end

		// Repeated label mismatch: count wrong labels inside a fixed window.
		if (s.win_cnt == 24'(WIN_CYCLES - 1))
		begin
			n.win_cnt = '0;
			n.wrong_cnt = '0;
		end
		else
		begin
			n.win_cnt = s.win_cnt + 24'd1;
			if (label_wrong && (s.wrong_cnt != `SDHB_LABEL_REPEAT))
			begin
				n.wrong_cnt = s.wrong_cnt + 3'd1;
			end
		end

		// Loss of frame: immediate, or after the hold-off when the timing bit is set.
		if (!out_of_frame)
		begin
			n.lof_cnt = '0;
			n.lof = 1'b0;
		end
		else if (!s.cfg_line[`SDHB_BIT_LOF_TIMING])
		begin
			n.lof = 1'b1;
		end
		else if (s.lof_cnt == 20'(LOF_CYCLES - 1))
		begin
			n.lof = 1'b1;
		end
		else
		begin
			n.lof_cnt = s.lof_cnt + 20'd1;
		end

		// Loss of signal release.
		case (s.los_st)
			SDHB_LOS_CLEAR:
			begin
				if (signal_loss_pin)
				begin
					n.los_st = SDHB_LOS_LOST;
				end
			end
			SDHB_LOS_LOST:
			begin
				n.pat_seen = 1'b0;
				if (!signal_loss_pin)
				begin
					n.los_st = s.cfg_line[`SDHB_BIT_LOS_RELEASE] ? SDHB_LOS_WAIT : SDHB_LOS_CLEAR;
				end
			end
			SDHB_LOS_WAIT:
			begin
				if (signal_loss_pin)
				begin
					n.los_st = SDHB_LOS_LOST;
				end
				else if (framing_pattern_ok)
				begin
					n.pat_seen = 1'b1;
					if (s.pat_seen)
					begin
						n.los_st = SDHB_LOS_CLEAR;
					end
				end
			end
			default:
			begin
				n.los_st = SDHB_LOS_LOST;  // An illegal code is treated as lost signal.
			end
		endcase
		n.los = (n.los_st != SDHB_LOS_CLEAR);

		// Excessive B2 consequences; path termination decides which far-end failure goes out.
		n.alarm_out = s.mode_high[`SDHB_BIT_XCB2] && excess_b2_detected;
		n.tx_section_ferf = n.alarm_out && !s.mode_low[`SDHB_BIT_PATH_TERM];
		n.tx_path_ferf = n.alarm_out && s.mode_low[`SDHB_BIT_PATH_TERM];

		// Pointer ss and dd bits: generated always, compared only when enabled.
		n.tx_ss = s.cfg_ptr[1:0];
		n.tx_dd = s.cfg_ptr[4:3];
		if (!s.cfg_ptr[`SDHB_BIT_SS_EVAL])
		begin
			n.ss_mismatch = 1'b0;
		end
		else if (h1_strobe)
		begin
			n.ss_mismatch = (rx_h1_first[3:2] != s.cfg_ptr[1:0]);
		end
		if (!s.cfg_ptr[`SDHB_BIT_DD_EVAL])
		begin
			n.dd_mismatch = 1'b0;
		end
		else if (h1_strobe)
		begin
			n.dd_mismatch = (rx_h1_later[3:2] != s.cfg_ptr[4:3]);
		end

		// Line settings chosen by the variant bits.
		n.ms_persist = s.cfg_line[`SDHB_BIT_MS_PERSIST] ? `SDHB_PERSIST_LONG : `SDHB_PERSIST_SHORT;
		n.k1k2_persist = s.cfg_line[`SDHB_BIT_K1K2_PERSIST] ? `SDHB_PERSIST_LONG : `SDHB_PERSIST_SHORT;
		n.pfail_persist = s.cfg_line[`SDHB_BIT_PFAIL_PERSIST] ? `SDHB_PFAIL_LONG : `SDHB_PERSIST_SHORT;
		n.lop_count = s.cfg_line[`SDHB_BIT_LOP_COUNT] ? `SDHB_LOP_SET : `SDHB_LOP_CLEAR;
		n.c1_second = s.cfg_line[`SDHB_BIT_C1_VARIANT] ? `SDHB_C1_SECOND : `SDHB_C1_FILL;
		n.c1_third = s.cfg_line[`SDHB_BIT_C1_VARIANT] ? `SDHB_C1_THIRD : `SDHB_C1_FILL;
		n.undef_fill = s.cfg_line[`SDHB_BIT_UNDEF_FILL] ? `SDHB_UNDEF_ZERO : `SDHB_UNDEF_ONES;
		n.fifo_extra = s.cfg_cell[`SDHB_BIT_OCTET_LEVEL] ? `SDHB_EXTRA_OCTET : `SDHB_EXTRA_SINGLE;
		n.tx_h4 = s.cfg_cell[`SDHB_BIT_H4_POINTER] ? next_cell_pointer : s.h4_value;
		n.laser_on = n.mode_high[`SDHB_BIT_LASER];
		n.irq = |(s.status & s.mask);

		// Software reset: everything but mode, config, the H4 value, the derived line outputs and the bus returns to reset while the bit is set.
		if (s.mode_low[`SDHB_BIT_CHIP_RESET])
		begin
			n.status = '0;
			n.mask = '0;
			n.accum = '0;
			n.latched = '0;
			n.frame_cnt = '0;
			n.lof_cnt = '0;
			n.lof = 1'b0;
			n.win_cnt = '0;
			n.wrong_cnt = '0;
			n.los_st = SDHB_LOS_CLEAR;
			n.pat_seen = 1'b0;
			n.los = 1'b0;
			n.irq = 1'b0;
			n.alarm_out = 1'b0;
			n.tx_section_ferf = 1'b0;
			n.tx_path_ferf = 1'b0;
			n.ss_mismatch = 1'b0;
			n.dd_mismatch = 1'b0;
		end
	end

	// State register with synchronous hardware reset.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			s <= rst_val;
		end
		else
		begin
			s <= n;
		end
	end

	// Outputs come straight from the state register.
	assign avs_readdata        = s.readdata;
	assign avs_waitrequest     = s.wait_req;
	assign irq                 = s.irq;
	assign loss_of_frame       = s.lof;
	assign loss_of_signal      = s.los;
	assign tx_section_ferf     = s.tx_section_ferf;
	assign tx_path_ferf        = s.tx_path_ferf;
	assign alarm_signal_output = s.alarm_out;
	assign laser_on            = s.laser_on;
	assign ss_mismatch         = s.ss_mismatch;
	assign dd_mismatch         = s.dd_mismatch;
	assign tx_h4               = s.tx_h4;
	assign ms_alarm_persist    = s.ms_persist;
	assign k1k2_persist        = s.k1k2_persist;
	assign path_fail_persist   = s.pfail_persist;
	assign pointer_loss_count  = s.lop_count;
	assign c1_second_byte      = s.c1_second;
	assign c1_third_byte       = s.c1_third;
	assign undefined_byte_fill = s.undef_fill;
	assign tx_fifo_extra_bytes = s.fifo_extra;
	assign tx_ss_bits          = s.tx_ss;
	assign tx_dd_bits          = s.tx_dd;

	sec_ferf_set_a: assert property (@(posedge mclk) disable iff (rst)
		(rx_k2[2:0] == 3'b110) && !s.mode_low[0] |=> s.status[0])
		else $error("section far-end flag not set");
	path_ferf_set_a: assert property (@(posedge mclk) disable iff (rst)
		rx_g1[3] && !s.mode_low[0] |=> s.status[1])
		else $error("path far-end flag not set");
	stuff_flag_a: assert property (@(posedge mclk) disable iff (rst)
		(tx_fifo_overflow || tx_fifo_underflow) && !s.mode_low[0] |=> s.status[2])
		else $error("stuffing error not flagged");
	timer_latch_a: assert property (@(posedge mclk) disable iff (rst)
		tick && !s.mode_low[0] |=> s.status[3] && (s.accum == 16'h0000) && s.latched[3])
		else $error("one-second latch missing");
	ext_pin_flag_a: assert property (@(posedge mclk) disable iff (rst)
		(!ext_irq_one_n || ext_irq_two) && !s.mode_low[0] |=> (s.status[7] || s.status[8]))
		else $error("external pin flag not set");
	label_repeat_a: assert property (@(posedge mclk) disable iff (rst)
		rpt_evt && !s.mode_low[0] |=> s.status[10] && s.status[9])
		else $error("repeated label mismatch not flagged");
	cell_ovf_a: assert property (@(posedge mclk) disable iff (rst)
		tx_cell_fifo_full && tx_cell_fifo_write && !s.mode_low[0] |=> s.status[11])
		else $error("cell fifo overflow not flagged");
	sw_reset_hold_a: assert property (@(posedge mclk) disable iff (rst)
		s.mode_low[0] |=> (s.status == 16'h0000) && !s.irq && (s.cfg_line == $past(s.cfg_line) || $past(wr_go)))
		else $error("software reset did not hold or lost config");
	laser_off_a: assert property (@(posedge mclk) disable iff (rst)
		auto_laser_shutdown |=> !s.laser_on && !s.mode_high[3])
		else $error("laser bit survived shutdown");
	b2_alarm_a: assert property (@(posedge mclk) disable iff (rst)
		excess_b2_detected && s.mode_high[0] && !s.mode_low[0] |=> s.alarm_out && (s.tx_section_ferf != s.tx_path_ferf))
		else $error("excess B2 consequences missing");
	lof_now_a: assert property (@(posedge mclk) disable iff (rst)
		out_of_frame && !s.cfg_line[6] && !s.lof && !s.mode_low[0] |=> s.lof)
		else $error("immediate frame loss not declared");
	lof_wait_a: assert property (@(posedge mclk) disable iff (rst)
		$rose(out_of_frame) && s.cfg_line[6] |=> !s.lof [*2])
		else $error("frame loss declared before hold-off");
	clear_blocked_a: assert property (@(posedge mclk) disable iff (rst)
		s.status[4] && !temperature_warning_n && !s.mode_low[0] |=> s.status[4])
		else $error("active status bit was cleared");
	irq_gate_a: assert property (@(posedge mclk) disable iff (rst)
		!s.mode_low[0] |=> s.irq == |($past(s.status) & $past(s.mask)))
		else $error("interrupt not equal to masked status");
	bus_answer_a: assert property (@(posedge mclk) disable iff (rst)
		(avs_read || avs_write) && s.wait_req |=> !s.wait_req ##1 s.wait_req)
		else $error("bus answer not one cycle");
endmodule

// file: tb/sdhb_cpu.sv
// Processor model: an Avalon-MM master making one register access at a time.
// Assumes the bank answers by dropping waitrequest; the bench bounds every wait.
`timescale 1ns/1ps
module sdhb_cpu (
	input  wire logic        mclk,
	input  wire logic        avs_waitrequest,
	input  wire logic [31:0] avs_readdata,
	output logic [5:0]       avs_address,
	output logic             avs_read,
	output logic             avs_write,
	output logic [31:0]      avs_writedata
);
	// Idle bus at time zero.
	initial
	begin
		avs_address = 6'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
	end
	// Request holds until waitrequest is sampled low; stale data is inverted so it is never reused.
	task automatic acc(input logic rd, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge mclk);
		avs_address <= a;
		avs_read <= rd;
		avs_write <= ~rd;
		avs_writedata <= d;
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0)
			@(posedge mclk);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_writedata <= ~d;
	endtask
endmodule

// file: tb/tb_top.sv
// Bench for the status, mode and config bank, driven through the processor model.
// Assumes one answer per access; all pins are driven here at rising edges.
`timescale 1ns/1ps
module tb_top;
	import sdhb_pkg::*;
	logic mclk = 1'b0, rst = 1'b1, path_select_pin = 1'b0, standard_select_pin = 1'b1, payload_mode_pin = 1'b0;
	logic frame_pulse = 1'b0, tx_fifo_overflow = 1'b0, tx_fifo_underflow = 1'b0, label_wrong = 1'b0;
	logic temperature_warning_n = 1'b1, supply_warning_n = 1'b1, battery_switchover_n = 1'b1, ext_irq_one_n = 1'b1;
	logic ext_irq_two = 1'b0, tx_cell_fifo_full = 1'b0, tx_cell_fifo_write = 1'b0, rx_cell_fifo_full = 1'b0;
	logic rx_cell_fifo_write = 1'b0, out_of_frame = 1'b0, signal_loss_pin = 1'b0, framing_pattern_ok = 1'b0;
	logic excess_b2_detected = 1'b0, auto_laser_shutdown = 1'b0, h1_strobe = 1'b0, avs_read, avs_write;
	logic [7:0] rx_k2 = 8'h0, rx_g1 = 8'h0, rx_h1_first = 8'h0, rx_h1_later = 8'h0, next_cell_pointer = 8'h3C;
	logic [5:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic avs_waitrequest, irq, loss_of_frame, loss_of_signal, tx_section_ferf, tx_path_ferf, alarm_signal_output;
	logic laser_on, ss_mismatch, dd_mismatch;
	logic [7:0] tx_h4, c1_second_byte, c1_third_byte, undefined_byte_fill;
	logic [3:0] ms_alarm_persist, k1k2_persist, path_fail_persist, pointer_loss_count;
	logic [2:0] tx_fifo_extra_bytes;
	logic [1:0] tx_ss_bits, tx_dd_bits;
	int n_fail = 0, cmp_count = 0, cyc = 0;
	sdhb_bank #(.LOF_CYCLES(20), .WIN_CYCLES(200)) dut (.*);
	sdhb_cpu cpu (.*);
	// Free-running 250 MHz clock.
	initial
		forever #2 mclk = ~mclk;
	// Ends the run with the counts and the verdict.
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// A hang counts as a mismatch.
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 12000)
		begin
			n_fail++;
			give_verdict();
		end
	end
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		cpu.acc(1'b0, a, d, q);
	endtask
	task automatic rd(input string nm, input logic [5:0] a, input logic [31:0] e);
		cpu.acc(1'b1, a, 32'h0, q);
		chk(nm, q, e);
	endtask
	// Main sequence; the loop interface bit is always written as one.
	initial
	begin
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		rd("mode_low", 6'h00, 32'h9C);
		rd("mode_high", 6'h04, 32'h80);
		rd("line_cfg", 6'h08, 32'h00);
		rd("cell_cfg", 6'h0C, 32'h8A);
		rd("ptr_cfg", 6'h10, 32'h16);
		chk("ss_dd", {tx_ss_bits, tx_dd_bits}, 4'hA);
		rd("unmapped", 6'h3C, 32'h0);
		$display("reset test done");
		{temperature_warning_n, supply_warning_n, battery_switchover_n, ext_irq_one_n} <= 4'h0;
		{ext_irq_two, tx_fifo_overflow, tx_cell_fifo_full, tx_cell_fifo_write} <= 4'hF;
		{rx_cell_fifo_full, rx_cell_fifo_write, rx_k2, rx_g1} <= {2'b11, 8'h06, 8'h08};
		wr(6'h18, 32'hFFFF);
		rd("status", 6'h18, 32'h19F7);
		chk("irq", irq, 1'b0);
		wr(6'h1C, 32'h0001);
		{temperature_warning_n, supply_warning_n, battery_switchover_n, ext_irq_one_n} <= 4'hF;
		{ext_irq_two, tx_fifo_overflow, tx_cell_fifo_full, tx_cell_fifo_write} <= 4'h0;
		{rx_cell_fifo_full, rx_cell_fifo_write, rx_k2, rx_g1} <= 18'h0;
		wr(6'h18, 32'h19F6);
		rd("status", 6'h18, 32'h0001);
		chk("irq", irq, 1'b1);
		wr(6'h18, 32'h0001);
		rd("status", 6'h18, 32'h0);
		chk("irq", irq, 1'b0);
		$display("status test done");
		out_of_frame <= 1'b1;
		rd("live", 6'h28, 32'h2);
		out_of_frame <= 1'b0;
		wr(6'h08, 32'h40);
		out_of_frame <= 1'b1;
		repeat (10) @(posedge mclk);
		chk("lof_early", loss_of_frame, 1'b0);
		repeat (15) @(posedge mclk);
		chk("lof_late", loss_of_frame, 1'b1);
		out_of_frame <= 1'b0;
		wr(6'h04, 32'h88);
		wr(6'h00, 32'h9D);
		rx_k2 <= 8'h06;
		rd("status_sw", 6'h18, 32'h0);
		rd("mode_high", 6'h04, 32'h88);
		rd("line_cfg", 6'h08, 32'h40);
		wr(6'h00, 32'h9C);
		rd("status_rel", 6'h18, 32'h0001);
		rx_k2 <= 8'h00;
		auto_laser_shutdown <= 1'b1;
		@(posedge mclk);
		auto_laser_shutdown <= 1'b0;
		rd("mode_high", 6'h04, 32'h80);
		wr(6'h04, 32'h88);
		rd("live", 6'h28, 32'h1);
		$display("reset and laser test done");
		for (int i = 0; i < 2; i++)
		begin
			wr(6'h08, i ? 32'h00 : 32'h9F);
			rd("line_cfg", 6'h08, i ? 32'h00 : 32'h9F);
			chk("fills", {c1_second_byte, c1_third_byte, undefined_byte_fill}, i ? 24'hAAAAFF : 24'h020300);
			chk("persist", {ms_alarm_persist, k1k2_persist}, i ? 8'h33 : 8'h55);
			chk("ptr_persist", {path_fail_persist, pointer_loss_count}, i ? 8'h39 : 8'hA8);
		end
		wr(6'h24, 32'h5A);
		rd("h4", 6'h24, 32'h5A);
		chk("h4_cpu", {tx_h4, tx_fifo_extra_bytes}, {8'h5A, 3'd1});
		wr(6'h0C, 32'hCE);
		rd("cell_cfg", 6'h0C, 32'hCE);
		chk("h4_ptr", {tx_h4, tx_fifo_extra_bytes}, {8'h3C, 3'd4});
		$display("config test done");
		wr(6'h04, 32'h89);
		excess_b2_detected <= 1'b1;
		repeat (2) @(posedge mclk);
		chk("b2_sec", {alarm_signal_output, tx_section_ferf, tx_path_ferf}, 3'b110);
		wr(6'h00, 32'hDC);
		repeat (2) @(posedge mclk);
		chk("b2_path", {alarm_signal_output, tx_section_ferf, tx_path_ferf}, 3'b101);
		excess_b2_detected <= 1'b0;
		for (int i = 0; i < 2; i++)
		begin
			wr(6'h08, i ? 32'h20 : 32'h00);
			signal_loss_pin <= 1'b1;
			repeat (2) @(posedge mclk);
			chk("los_set", loss_of_signal, 1'b1);
			signal_loss_pin <= 1'b0;
			repeat (2) @(posedge mclk);
			chk("los_hold", loss_of_signal, i);
			framing_pattern_ok <= 1'b1;
			repeat (2) @(posedge mclk);
			chk("los_one", loss_of_signal, i);
			framing_pattern_ok <= 1'b0;
			@(posedge mclk);
			chk("los_rel", loss_of_signal, 1'b0);
		end
		for (int i = 0; i < 3; i++)
		begin
			wr(6'h10, i == 2 ? 32'h12 : 32'h36);
			{rx_h1_first, rx_h1_later, h1_strobe} <= {i == 1 ? 8'h08 : 8'h00, i == 0 ? 8'h08 : 8'h00, 1'b1};
			@(posedge mclk);
			h1_strobe <= 1'b0;
			@(posedge mclk);
			chk("ss_dd_cmp", {ss_mismatch, dd_mismatch}, i == 0 ? 2'b10 : i == 1 ? 2'b01 : 2'b00);
		end
		$display("alarm test done");
		wr(6'h18, 32'hFFFF);
		label_wrong <= 1'b1;
		repeat (10) @(posedge mclk);
		label_wrong <= 1'b0;
		frame_pulse <= 1'b1;
		repeat (8000) @(posedge mclk);
		frame_pulse <= 1'b0;
		rd("status_sec", 6'h18, 32'h0608);
		rd("latched", 6'h20, 32'h0609);
		$display("timer test done");
		{rst, path_select_pin, standard_select_pin} <= 3'b110;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		rd("mode_low", 6'h00, 32'hFC);
		rd("line_cfg", 6'h08, 32'hFF);
		rd("cell_cfg", 6'h0C, 32'h8B);
		rd("ptr_cfg", 6'h10, 32'h00);
		$display("second reset test done");
		give_verdict();
	end
endmodule
